/* File: logic/sio_pkg.sv */
// Purpose: shared constants for the secure i/o block
// Assumes: apb with 32-bit data, 40 mhz clock
// Notes: register offsets are byte addresses
`default_nettype none
package sio_pkg;
  localparam logic [7:0] SIO_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SIO_ADDR_TRIG = 8'h04;
  localparam logic [7:0] SIO_ADDR_DUR = 8'h08;
  localparam logic [7:0] SIO_ADDR_WDT = 8'h0c;
  localparam logic [7:0] SIO_ADDR_CMD = 8'h10;
  localparam logic [7:0] SIO_ADDR_STAT = 8'h14;
  localparam logic [7:0] SIO_ADDR_IRQ_ST = 8'h18;
  localparam logic [7:0] SIO_ADDR_IRQ_EN = 8'h1c;
  localparam logic [7:0] SIO_ADDR_IRQ_CLR = 8'h20;
  // ctrl bit positions
  localparam int SIO_C_TAMP_EN = 0;
  localparam int SIO_C_EVT_EN = 1;
  localparam int SIO_C_EVT_POL = 2;
  localparam int SIO_C_EVT_PULSE = 3;
  localparam int SIO_C_WDT_EN = 4;
  localparam int SIO_C_OP_OK = 5;
  localparam logic [31:0] SIO_CTRL_RST = 32'h0000_0020;
  // cmd register bits
  localparam int SIO_K_BOOT_DONE = 0;
  localparam int SIO_K_BUSY = 1;
  // event indices
  localparam int SIO_NEV = 8;
  localparam int SIO_E_BOOT_OK = 0;
  localparam int SIO_E_BOOT_FAIL = 1;
  localparam int SIO_E_CHAN_OK = 2;
  localparam int SIO_E_CHAN_ERR = 3;
  localparam int SIO_E_TAMPER = 4;
  localparam int SIO_E_CONSIST = 5;
  localparam int SIO_E_POR = 6;
  localparam int SIO_E_WDT = 7;
  localparam int SIO_CLK_HZ = 40000000;
  localparam int SIO_DUR_W = 24;
  localparam logic [23:0] SIO_DUR_RST = 24'h000028;
  localparam logic [31:0] SIO_WDT_RST = 32'h0002_7100;
  typedef enum logic [1:0] {
    SIO_EV_IDLE = 2'b00,
    SIO_EV_DRIVE = 2'b01,
    SIO_EV_HOLD = 2'b10
  } sio_ev_st_t;
endpackage : sio_pkg
`default_nettype wire

/* File: logic/sio_evt_out.sv */
// Purpose: drives the secure event pin for a set time or holds it
// Assumes: trig is a one-cycle pulse
// Notes: pin is released to open-drain when idle
`default_nettype none
module sio_evt_out
  import sio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic polarity,
  input wire logic pulse_mode,
  input wire logic [SIO_DUR_W-1:0] duration,
  input wire logic trig,
  input wire logic release_hold,
  output logic pin_o,
  output logic pin_oe
);
  sio_ev_st_t st, next_st;
  logic [SIO_DUR_W-1:0] cnt, next_cnt;
  logic next_o, next_oe;
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    case (st)
      SIO_EV_IDLE: begin
        if (enable && trig) begin
          next_st = pulse_mode ? SIO_EV_DRIVE : SIO_EV_HOLD;
          next_cnt = duration;
        end
      end
      SIO_EV_DRIVE: begin
        if (cnt <= 24'h000001) begin
          next_st = SIO_EV_IDLE;
        end else begin
          next_cnt = cnt - 24'h000001;
        end
      end
      SIO_EV_HOLD: begin
        if (release_hold) begin
          next_st = SIO_EV_IDLE;
        end
      end
      default: next_st = SIO_EV_IDLE;
    endcase
    if (!enable) begin
      next_st = SIO_EV_IDLE;
    end
    next_oe = (next_st != SIO_EV_IDLE);
    next_o = next_oe ? polarity : 1'b0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= SIO_EV_IDLE;
      cnt <= '0;
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      pin_o <= next_o;
      pin_oe <= next_oe;
    end
  end
  a_evt_release: assert property (@(posedge clk) disable iff (rst)
    !enable |=> !pin_oe) else $error("event pin driven while disabled");
endmodule : sio_evt_out
`default_nettype wire

/* File: logic/sio_wdt.sv */
// Purpose: watchdog on the kick input
// Assumes: kick synchronous to clk
// Notes: any edge of the kick restarts the count
`default_nettype none
module sio_wdt
  import sio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [31:0] timeout,
  input wire logic kick,
  output logic expired
);
  logic kick_d, next_kick_d;
  logic [31:0] cnt, next_cnt;
  logic next_exp;
  always_comb begin
    next_kick_d = kick;
    next_cnt = cnt;
    next_exp = 1'b0;
    if (!enable) begin
      next_cnt = '0;
    end else if (kick != kick_d) begin
      next_cnt = '0;
    end else if (cnt + 32'h1 >= timeout) begin
      next_cnt = '0;
      next_exp = 1'b1;
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_d <= 1'b0;
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      kick_d <= next_kick_d;
      cnt <= next_cnt;
      expired <= next_exp;
    end
  end
  a_wdt_quiet: assert property (@(posedge clk) disable iff (rst)
    !enable |=> !expired) else $error("watchdog fired while disabled");
endmodule : sio_wdt
`default_nettype wire

/* File: logic/sio_top.sv */
// Purpose: tamper input, secure event output, watchdog and command ready
// Assumes: apb slave, single 40 mhz clock, pins synchronous
// Notes: event pin is open-drain style: output plus enable
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
// Overview of operation
// - tamper counts only when powered, power_down_n high and conditions valid
// - enabled tamper detection starts the response while tamper input is low
// - tamper detection is off after reset
// - event output off after reset and not driven until enabled
// - enabled event output stays undriven while no event is active
// - on a chosen event drive polarity level for set time, then release
// - event output either holds its level or emits a pulse
// - watchdog off after reset; kick input ignored while off
// - ready low while busy or unable to take a command
// - ready high after boot once commands can be taken
// - ready high when command processing finishes
// - power_down_n low erases volatile state; host holds it high when active
// - tamper input is active low and reads inactive when open
// - event triggers: boot, channel, tamper, consistency, power-on, watchdog
module sio_top
  import sio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_n,
  input wire logic tamper_n,
  input wire logic watchdog_kick_in,
  input wire logic boot_ok_in,
  input wire logic boot_fail_in,
  input wire logic chan_ok_in,
  input wire logic chan_err_in,
  input wire logic consist_err_in,
  input wire logic cmd_start_in,
  input wire logic cmd_done_in,
  output logic tamper_resp,
  output logic evt_o,
  output logic evt_oe,
  output logic cmd_ready,
  output logic irq
);
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic [31:0] ctrl, next_ctrl;
  logic [SIO_NEV-1:0] trig_sel, next_trig_sel;
  logic [SIO_DUR_W-1:0] dur, next_dur;
  logic [31:0] wdt_to, next_wdt_to;
  logic [SIO_NEV-1:0] irq_st, next_irq_st, irq_en, next_irq_en;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic booted, next_booted, busy, next_busy, next_cmd_ready;
  logic por_pend, next_por_pend;
  logic tamp_lvl, next_tamp_resp, next_irq;
  logic wdt_exp, ev_release, cmd_wr, cmd_clr;
  logic [SIO_NEV-1:0] events;
  logic wr, rd, hit, acc;

  // access phase seen, answer not yet given
  assign acc = psel && penable && !pready;
  // a write lands only at the edge that completes the transfer
  assign wr = psel && penable && pwrite && pready;
  assign rd = acc && !pwrite;
  assign hit = is_addr(paddr, SIO_ADDR_CTRL) || is_addr(paddr, SIO_ADDR_TRIG) ||
    is_addr(paddr, SIO_ADDR_DUR) || is_addr(paddr, SIO_ADDR_WDT) ||
    is_addr(paddr, SIO_ADDR_CMD) || is_addr(paddr, SIO_ADDR_STAT) ||
    is_addr(paddr, SIO_ADDR_IRQ_ST) || is_addr(paddr, SIO_ADDR_IRQ_EN) ||
    is_addr(paddr, SIO_ADDR_IRQ_CLR);
  assign cmd_wr = wr && is_addr(paddr, SIO_ADDR_CMD);
  assign cmd_clr = cmd_wr && pwdata[SIO_K_BUSY];
  assign ev_release = wr && is_addr(paddr, SIO_ADDR_STAT);

  // tamper qualified by power, power_down_n and valid operation
  assign tamp_lvl = ctrl[SIO_C_TAMP_EN] && !tamper_n && power_down_n &&
    ctrl[SIO_C_OP_OK];

  always_comb begin
    events = '0;
    events[SIO_E_BOOT_OK] = boot_ok_in;
    events[SIO_E_BOOT_FAIL] = boot_fail_in;
    events[SIO_E_CHAN_OK] = chan_ok_in;
    events[SIO_E_CHAN_ERR] = chan_err_in;
    events[SIO_E_TAMPER] = tamp_lvl && !tamper_resp;
    events[SIO_E_CONSIST] = consist_err_in;
    events[SIO_E_POR] = por_pend;
    events[SIO_E_WDT] = wdt_exp;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_trig_sel = trig_sel;
    next_dur = dur;
    next_wdt_to = wdt_to;
    next_irq_en = irq_en;
    next_irq_st = irq_st;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (acc) begin
      next_pready = 1'b1;
      next_pslverr = !hit;
    end
    if (wr) begin
      if (is_addr(paddr, SIO_ADDR_CTRL)) next_ctrl = pwdata;
      if (is_addr(paddr, SIO_ADDR_TRIG)) next_trig_sel = pwdata[SIO_NEV-1:0];
      if (is_addr(paddr, SIO_ADDR_DUR)) next_dur = pwdata[SIO_DUR_W-1:0];
      if (is_addr(paddr, SIO_ADDR_WDT)) next_wdt_to = pwdata;
      if (is_addr(paddr, SIO_ADDR_IRQ_EN)) next_irq_en = pwdata[SIO_NEV-1:0];
      if (is_addr(paddr, SIO_ADDR_IRQ_CLR)) next_irq_st = irq_st & ~pwdata[SIO_NEV-1:0];
    end
    next_irq_st = next_irq_st | events;
    if (rd) begin
      next_prdata = '0;
      case (paddr)
        SIO_ADDR_CTRL: next_prdata = ctrl;
        SIO_ADDR_TRIG: next_prdata[SIO_NEV-1:0] = trig_sel;
        SIO_ADDR_DUR: next_prdata[SIO_DUR_W-1:0] = dur;
        SIO_ADDR_WDT: next_prdata = wdt_to;
        SIO_ADDR_CMD: next_prdata[1:0] = {busy, booted};
        SIO_ADDR_STAT: next_prdata[2:0] = {cmd_ready, tamper_resp, evt_oe};
        SIO_ADDR_IRQ_ST: next_prdata[SIO_NEV-1:0] = irq_st;
        SIO_ADDR_IRQ_EN: next_prdata[SIO_NEV-1:0] = irq_en;
        default: next_prdata = '0;
      endcase
    end
    if (!power_down_n) begin
      next_irq_st = '0;
    end
    next_irq = |(next_irq_st & next_irq_en);
  end

  // command ready: low until boot done, low while busy
  always_comb begin
    next_booted = booted;
    next_busy = busy;
    next_por_pend = 1'b0;
    next_tamp_resp = tamp_lvl;
    if (cmd_wr && pwdata[SIO_K_BOOT_DONE]) next_booted = 1'b1;
    if (cmd_start_in && booted) next_busy = 1'b1;
    if (cmd_done_in || cmd_clr) next_busy = 1'b0;
    if (!power_down_n) begin
      next_busy = 1'b0;
      next_booted = 1'b0;
    end
    next_cmd_ready = next_booted && !next_busy;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= SIO_CTRL_RST;
      trig_sel <= '0;
      dur <= SIO_DUR_RST;
      wdt_to <= SIO_WDT_RST;
      irq_st <= '0;
      irq_en <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      booted <= 1'b0;
      busy <= 1'b0;
      cmd_ready <= 1'b0;
      por_pend <= 1'b1;
      tamper_resp <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      trig_sel <= next_trig_sel;
      dur <= next_dur;
      wdt_to <= next_wdt_to;
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      booted <= next_booted;
      busy <= next_busy;
      cmd_ready <= next_cmd_ready;
      por_pend <= next_por_pend;
      tamper_resp <= next_tamp_resp;
    end
  end

  sio_wdt u_wdt (
    .clk(clk),
    .rst(rst),
    .enable(ctrl[SIO_C_WDT_EN] && power_down_n),
    .timeout(wdt_to),
    .kick(watchdog_kick_in),
    .expired(wdt_exp)
  );

  sio_evt_out u_evt (
    .clk(clk),
    .rst(rst),
    .enable(ctrl[SIO_C_EVT_EN]),
    .polarity(ctrl[SIO_C_EVT_POL]),
    .pulse_mode(ctrl[SIO_C_EVT_PULSE]),
    .duration(dur),
    .trig(|(events & trig_sel)),
    .release_hold(ev_release),
    .pin_o(evt_o),
    .pin_oe(evt_oe)
  );

  a_tamp_gate: assert property (@(posedge clk) disable iff (rst)
    (!ctrl[SIO_C_TAMP_EN] || !power_down_n) |=> !tamper_resp)
    else $error("tamper response while gated");
  a_tamp_fire: assert property (@(posedge clk) disable iff (rst)
    (ctrl[SIO_C_TAMP_EN] && ctrl[SIO_C_OP_OK] && power_down_n && !tamper_n) |=> tamper_resp)
    else $error("tamper low not answered");
  a_rdy_busy: assert property (@(posedge clk) disable iff (rst)
    (busy && !cmd_done_in && !cmd_clr) |=> !cmd_ready)
    else $error("ready high while busy");
  a_rdy_boot: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && pwdata[SIO_K_BOOT_DONE] && !busy && power_down_n && !cmd_start_in) |=> cmd_ready)
    else $error("ready not raised after boot");
  a_rdy_done: assert property (@(posedge clk) disable iff (rst)
    (booted && busy && cmd_done_in && power_down_n) |=> cmd_ready)
    else $error("ready not raised after done");
  a_evt_idle: assert property (@(posedge clk) disable iff (rst)
    (evt_oe == 1'b0) |-> (evt_o == 1'b0))
    else $error("event level without drive");
  a_evt_fire: assert property (@(posedge clk) disable iff (rst)
    (ctrl[SIO_C_EVT_EN] && !evt_oe && |(events & trig_sel) && $stable(ctrl)) |=>
    (evt_oe && evt_o == ctrl[SIO_C_EVT_POL]))
    else $error("event pin not driven");
  a_pdn_clear: assert property (@(posedge clk) disable iff (rst)
    !power_down_n |=> (!cmd_ready && !tamper_resp))
    else $error("state kept in power-down");
endmodule : sio_top
`default_nettype wire

/* File: sim/sio_host_mdl.sv */
// Purpose: host controller and tamper sensor model
// Assumes: same clock as the block
// Notes: pins change just after the rising edge
`default_nettype none
module sio_host_mdl (
  input wire logic clk,
  input wire logic sleep,
  input wire logic sensor_closed,
  input wire logic kick_on,
  input wire logic send_cmd,
  input wire logic cmd_ready,
  output logic power_down_n,
  output logic tamper_n,
  output logic watchdog_kick_in,
  output logic cmd_start_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] kcnt;
  initial begin
    power_down_n = 1'b1;
    tamper_n = 1'b1;
    watchdog_kick_in = 1'b0;
    cmd_start_in = 1'b0;
    kcnt = 3'h0;
  end
  always @(posedge clk) begin
    power_down_n <= !sleep;
    tamper_n <= !sensor_closed; // open sensor pulled high
    kcnt <= kcnt + 3'h1;
    if (kick_on && kcnt == 3'h7) begin
      watchdog_kick_in <= !watchdog_kick_in;
    end
    cmd_start_in <= send_cmd && cmd_ready && !cmd_start_in;
  end
endmodule // sio_host_mdl
`default_nettype wire

/* File: sim/secure_io_tamper_ready_tb.sv */
// Purpose: self-checking bench for the secure i/o block
// Assumes: apb master and host model on one 40 mhz clock
// Notes: event pin level taken from output and enable
`default_nettype none
module secure_io_tamper_ready_tb
  import sio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, tamper_resp, evt_o, evt_oe, cmd_ready, irq;
  logic power_down_n, tamper_n, watchdog_kick_in, cmd_start_in;
  logic sleep = 1'b0, sensor_closed = 1'b0, kick_on = 1'b0, send_cmd = 1'b0;
  logic cmd_done_in = 1'b0;
  logic [5:0] ev = 6'h00;
  int error_cnt = 0, n_tests = 0, cyc = 0, hi;
  always #12.5 clk = !clk;
  sio_host_mdl host_u (.clk(clk), .sleep(sleep), .sensor_closed(sensor_closed),
    .kick_on(kick_on), .send_cmd(send_cmd), .cmd_ready(cmd_ready),
    .power_down_n(power_down_n), .tamper_n(tamper_n),
    .watchdog_kick_in(watchdog_kick_in), .cmd_start_in(cmd_start_in));
  sio_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .tamper_n(tamper_n), .watchdog_kick_in(watchdog_kick_in),
    .boot_ok_in(ev[0]), .boot_fail_in(ev[1]), .chan_ok_in(ev[2]), .chan_err_in(ev[3]),
    .consist_err_in(ev[5]), .cmd_start_in(cmd_start_in), .cmd_done_in(cmd_done_in),
    .tamper_resp(tamper_resp), .evt_o(evt_o), .evt_oe(evt_oe), .cmd_ready(cmd_ready),
    .irq(irq));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic fire(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic watch(input int n, input logic pol);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      if (evt_oe === 1'b1) begin
        hi++;
        chk("evt_o", evt_o, pol);
      end
    end
  endtask
  task automatic t_reset();
    chk("evt_oe", evt_oe, 0);
    chk("cmd_ready", cmd_ready, 0);
    rdc("ctrl", SIO_ADDR_CTRL, 32'h13, 32'h0);
    rdc("por", SIO_ADDR_IRQ_ST, 32'h40, 32'h40);
    rdc("unmapped", 8'h24, 32'hffffffff, 32'h0);
    chk("slverr", er, 1);
  endtask
  task automatic t_irq();
    chk("irq_masked", irq, 0);
    wr(SIO_ADDR_IRQ_EN, 32'h40);
    tick(1);
    chk("irq_set", irq, 1);
    wr(SIO_ADDR_IRQ_CLR, 32'h40);
    tick(1);
    chk("irq_clr", irq, 0);
    rdc("por_clr", SIO_ADDR_IRQ_ST, 32'h40, 32'h0);
  endtask
  task automatic t_tamper();
    sensor_closed <= 1'b1;
    tick(4);
    chk("tamp_off", tamper_resp, 0);
    wr(SIO_ADDR_CTRL, 32'h21);
    tick(3);
    chk("tamp_on", tamper_resp, 1);
    rdc("tamp_evt", SIO_ADDR_IRQ_ST, 32'h10, 32'h10);
    sleep <= 1'b1;
    tick(3);
    chk("tamp_pd", tamper_resp, 0);
    sleep <= 1'b0;
    wr(SIO_ADDR_CTRL, 32'h01);
    tick(3);
    chk("tamp_cond", tamper_resp, 0);
    sensor_closed <= 1'b0;
    wr(SIO_ADDR_CTRL, 32'h21);
    tick(3);
    chk("tamp_open", tamper_resp, 0);
  endtask
  task automatic t_evt();
    wr(SIO_ADDR_CTRL, 32'h20);
    wr(SIO_ADDR_TRIG, 32'h20);
    fire(5);
    watch(8, 1'b0);
    chk("evt_dis", hi, 0);
    wr(SIO_ADDR_DUR, 32'h3);
    wr(SIO_ADDR_CTRL, 32'h2a);
    tick(4);
    chk("evt_idle", evt_oe, 0);
    for (int i = 0; i < 6; i++) begin
      if (i != 4) begin
        wr(SIO_ADDR_TRIG, 32'h1 << i);
        fire((i + 3) % 6);
        watch(6, 1'b0);
        chk("evt_unsel", hi, 0);
        fire(i);
        watch(10, 1'b0);
        chk("evt_pulse", hi, 3);
      end
    end
    wr(SIO_ADDR_CTRL, 32'h26);
    fire(5);
    tick(20);
    chk("hold_oe", evt_oe, 1);
    chk("hold_lvl", evt_o, 1);
    wr(SIO_ADDR_STAT, 32'h0);
    tick(2);
    chk("hold_rel", evt_oe, 0);
    wr(SIO_ADDR_CTRL, 32'h20);
  endtask
  task automatic t_wdt();
    wr(SIO_ADDR_WDT, 32'h10);
    tick(40);
    rdc("wdt_off", SIO_ADDR_IRQ_ST, 32'h80, 32'h0);
    kick_on <= 1'b1;
    wr(SIO_ADDR_CTRL, 32'h30);
    tick(60);
    rdc("wdt_kick", SIO_ADDR_IRQ_ST, 32'h80, 32'h0);
    kick_on <= 1'b0;
    tick(40);
    rdc("wdt_exp", SIO_ADDR_IRQ_ST, 32'h80, 32'h80);
    wr(SIO_ADDR_CTRL, 32'h20);
  endtask
  task automatic t_cmd();
    int n;
    n = 0;
    send_cmd <= 1'b1;
    tick(6);
    chk("rdy_boot", cmd_ready, 0);
    send_cmd <= 1'b0;
    wr(SIO_ADDR_CMD, 32'h1);
    tick(2);
    chk("rdy_up", cmd_ready, 1);
    send_cmd <= 1'b1;
    while (cmd_ready === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    send_cmd <= 1'b0;
    tick(4);
    chk("rdy_busy", cmd_ready, 0);
    cmd_done_in <= 1'b1;
    tick(1);
    cmd_done_in <= 1'b0;
    tick(2);
    chk("rdy_done", cmd_ready, 1);
    sleep <= 1'b1;
    tick(2);
    sleep <= 1'b0;
    tick(2);
    chk("rdy_pd", cmd_ready, 0);
  endtask
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_irq();
    t_tamper();
    t_evt();
    t_wdt();
    t_cmd();
    print_verdict();
  end
endmodule // secure_io_tamper_ready_tb
`default_nettype wire
